// ---- spief_pkg.sv ----
// constants shared by the serial eeprom front end
package spief_pkg;

    // opcode values, most significant bit first on the wire
    localparam logic [7:0] OP_SET_PERMIT   = 8'h06;
    localparam logic [7:0] OP_CLEAR_PERMIT = 8'h04;
    localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
    localparam logic [7:0] OP_STATUS_STORE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

    // status byte field positions
    localparam int ST_LOCK_BIT   = 7;
    localparam int ST_GUARD_HI   = 3;
    localparam int ST_GUARD_LO   = 2;
    localparam int ST_PERMIT_BIT = 1;
    localparam int ST_BUSY_BIT   = 0;

    // area guard encodings
    localparam logic [1:0] GUARD_NONE    = 2'h0;
    localparam logic [1:0] GUARD_QUARTER = 2'h1;
    localparam logic [1:0] GUARD_HALF    = 2'h2;
    localparam logic [1:0] GUARD_ALL     = 2'h3;

    // reset values
    localparam logic       PERMIT_RST = 1'h0;
    localparam logic [1:0] GUARD_RST  = 2'h0;
    localparam logic       LOCK_RST   = 1'h0;

    // framing: bits per byte, bytes per instruction kind
    localparam logic [2:0] LAST_BIT_IDX   = 3'h7;
    localparam logic [7:0] BYTES_SIMPLE   = 8'h01;
    localparam logic [7:0] BYTES_STORE    = 8'h02;
    localparam logic [7:0] BYTES_WR_MIN   = 8'h04;
    localparam logic [7:0] BYTE_IDX_ADDRH = 8'h01;
    localparam logic [7:0] BYTE_IDX_ADDRL = 8'h02;

    // self-timed programming time
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_US  = 100;
    localparam int PROG_CYCLES   = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;

    // busy sequencer states, gray coded along idle-array / idle-status
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ARRAY  = 2'b01,
        ST_STATUS = 2'b10
    } spief_state_e;

endpackage

// ---- spief_front_end.sv ----
// serial eeprom slave front end: link shifter, status and busy sequencer
// Function
// - serial_in is captured on each rising edge of the serial clock.
// - serial_out changes only after falling edges, one bit per edge.
// - deselected means output disabled; standby only when no write runs.
// - after reset no select is honoured until chip enable was seen high.
// - all bytes move most significant bit first in both directions.
// - first opcode bit is the first rising edge after select.
// - read data starts on first falling edge after the full instruction.
// - during pause output is disabled and clock and data are ignored.
// - pause starts and ends on pause pin edges while clock is low.
// - bit position and instruction state survive a pause.
// - deselect during pause resets the interface state.
// - while supply reset is active nothing is executed.
// - writes and status stores need a clock count that is a multiple of 8.
// - modifying instructions need the permit latch set beforehand.
// - permit latch clears on reset, clear, status store and write done.
// - instruction executes only if deselect follows its last rising edge.
// - last bit is eighth of opcode or data byte; reads are exempt.
// - area guard blocks none, top quarter, top half or whole array.
// - lock bit plus low protect pin makes lock and guard bits read-only.
// - busy flag is set exactly while a self-timed cycle runs.
// - the six opcodes are decoded from 8-bit values.
// - unknown opcode: device drops out for the rest of the transfer.
// - status store keeps bits 7,3,2; bits 6 to 4 read as zero.
`timescale 1ns/10ps
`default_nettype none

module spief_front_end
    import spief_pkg::*;
#(
    parameter int ADDR_W      = 15,          // array address width
    parameter int PROG_CYC    = PROG_CYCLES  // self-timed cycle length
)(
    input  wire logic              clk_sys,            // system clock
    input  wire logic              sys_rst,            // supply reset, high
    input  wire logic              clk_en,             // freezes sys state
    input  wire logic              shift_timing_input, // serial clock
    input  wire logic              chip_enable_n,      // select, low
    input  wire logic              serial_in,          // data from master
    input  wire logic              pause_pin_n,        // pause, low
    input  wire logic              protect_pin_n,      // protect, low
    input  wire logic [7:0]        array_data,         // byte at array_addr
    output logic                   serial_out,         // data to master
    output logic                   serial_out_oe,      // output drive enable
    output logic [ADDR_W-1:0]      array_addr,         // read address
    output logic                   busy_flag           // self-timed cycle
);

    // refuse sizes the address logic cannot serve
    if (ADDR_W < 2 || ADDR_W > 16) begin : g_bad_addr
        $error("ADDR_W must lie between 2 and 16");
    end
    if (PROG_CYC < 2) begin : g_bad_prog
        $error("PROG_CYC must be at least 2");
    end

    // ---------------- link domain, serial clock ----------------
    logic        lk_in_frame;   // a rising edge has been taken this frame
    logic [2:0]  lk_cnt_lo;     // bit index within current byte
    logic [7:0]  lk_byte_cnt;   // completed bytes, saturating
    logic [7:0]  lk_sh;         // incoming shifter
    logic [7:0]  lk_opcode;
    logic [7:0]  lk_b1;         // address high or status data byte
    logic [7:0]  lk_b2;         // address low
    logic        lk_load;       // reload output shifter at next fall
    logic        lk_sel_stat;   // reload source is the status byte
    logic [7:0]  lk_osh;        // outgoing shifter
    logic        lk_out_act;    // device has started returning data
    logic [7:0]  lk_st_m1;      // status byte synchroniser
    logic [7:0]  lk_st_m2;
    logic [2:0]  lk_cnt_cur;
    logic [7:0]  lk_byte_cur;
    logic [7:0]  lk_b;
    logic        next_load;
    logic        next_sel_stat;
    logic [7:0]  lk_load_val;

    // a stale count from the last frame is replaced, not reset, here
    always_comb
    begin
        lk_cnt_cur    = lk_in_frame ? lk_cnt_lo : 3'h0;
        lk_byte_cur   = lk_in_frame ? lk_byte_cnt : 8'h00;
        lk_b          = {lk_sh[6:0], serial_in};
        next_load     = 1'b0;
        next_sel_stat = lk_sel_stat;
        if (lk_cnt_cur == LAST_BIT_IDX)
        begin
            if (lk_byte_cur == 8'h00)
            begin
                next_load     = (lk_b == OP_STATUS_FETCH);
                next_sel_stat = 1'b1;
            end
            else if (lk_opcode == OP_STATUS_FETCH)
            begin
                next_load     = 1'b1;                      // repeated status
                next_sel_stat = 1'b1;
            end
            else if (lk_opcode == OP_ARRAY_READ &&
                     lk_byte_cur >= BYTE_IDX_ADDRL)
            begin
                next_load     = 1'b1;
                next_sel_stat = 1'b0;
            end
        end
    end

    // frame marker, cleared by deselect even in mid pause
    always_ff @(posedge shift_timing_input or posedge chip_enable_n)
    begin
        if (chip_enable_n)
            lk_in_frame <= 1'b0;
        else if (pause_pin_n)
            lk_in_frame <= 1'b1;
    end

    // input capture; a low pause pin at a rising edge means paused
    always_ff @(posedge shift_timing_input)
    begin
        if (pause_pin_n && !chip_enable_n)
        begin
            lk_cnt_lo   <= lk_cnt_cur + 3'h1;
            lk_sh       <= lk_b;
            lk_load     <= next_load;
            lk_sel_stat <= next_sel_stat;
            lk_byte_cnt <= lk_byte_cur;
            if (lk_cnt_cur == LAST_BIT_IDX)
            begin
                if (lk_byte_cur != 8'hFF)
                    lk_byte_cnt <= lk_byte_cur + 8'h01;
                if (lk_byte_cur == 8'h00)
                    lk_opcode <= lk_b;
                else if (lk_byte_cur == BYTE_IDX_ADDRH)
                    lk_b1 <= lk_b;
                else if (lk_byte_cur == BYTE_IDX_ADDRL)
                begin
                    lk_b2      <= lk_b;
                    array_addr <= ADDR_W'({lk_b1, lk_b});
                end
                else if (lk_opcode == OP_ARRAY_READ)
                    array_addr <= array_addr + ADDR_W'(1);
            end
        end
    end

    // status byte settles long before a fetch opcode completes
    always_ff @(posedge shift_timing_input)
    begin
        lk_st_m1 <= stat_q;
        lk_st_m2 <= lk_st_m1;
    end

    assign lk_load_val = lk_sel_stat ? lk_st_m2 : array_data;

    // output shifter; mode 3 leading fall is ignored as no frame yet
    always_ff @(negedge shift_timing_input)
    begin
        if (pause_pin_n && lk_in_frame)
        begin
            if (lk_load)
            begin
                serial_out <= lk_load_val[7];
                lk_osh     <= {lk_load_val[6:0], 1'b0};
            end
            else
            begin
                serial_out <= lk_osh[7];
                lk_osh     <= {lk_osh[6:0], 1'b0};
            end
        end
    end

    // data phase marker, dropped by deselect
    always_ff @(negedge shift_timing_input or posedge chip_enable_n)
    begin
        if (chip_enable_n)
            lk_out_act <= 1'b0;
        else if (pause_pin_n && lk_in_frame && lk_load)
            lk_out_act <= 1'b1;
    end

    // ---------------- system domain ----------------
    logic [2:0]   cs_m;         // three-stage pin samplers
    logic [2:0]   ps_m;
    logic [2:0]   pr_m;
    logic         cs_st;        // filtered chip enable, high = deselected
    logic         ps_st;        // filtered pause, low = paused
    logic         pr_st;        // filtered protect
    logic [2:0]   act_m;        // data phase marker synchroniser
    logic         armed;        // chip enable seen high since reset
    logic         frame_ok;     // current frame began while armed
    logic         permit;       // modify_permit_latch
    logic [1:0]   guard;        // area_guard_hi, area_guard_lo
    logic         lock;         // status_lock_bit
    logic [7:0]   pend;         // status value waiting for cycle end
    logic [7:0]   stat_q;       // registered status byte
    logic [31:0]  prog_cnt;
    spief_state_e state;
    logic         cs_rise;
    logic         cs_fall;
    logic         exec;
    logic         bits_ok;
    logic         pin_lock;
    logic         guarded;
    logic [15:0]  wr_addr_w;
    logic [1:0]   top2;
    logic         prog_done;

    // first stage feeds only the second; a change counts when 2 and 3 agree
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cs_m  <= 3'h0;          // low until seen high: no false arm
            ps_m  <= 3'h7;
            pr_m  <= 3'h7;
            cs_st <= 1'b0;
            ps_st <= 1'b1;
            pr_st <= 1'b1;
            act_m <= 3'h0;
        end
        else if (clk_en)
        begin
            cs_m  <= {cs_m[1:0], chip_enable_n};
            ps_m  <= {ps_m[1:0], pause_pin_n};
            pr_m  <= {pr_m[1:0], protect_pin_n};
            act_m <= {act_m[1:0], lk_out_act};
            if (cs_m[1] == cs_m[2])
                cs_st <= cs_m[2];
            if (ps_m[1] == ps_m[2])
                ps_st <= ps_m[2];
            if (pr_m[1] == pr_m[2])
                pr_st <= pr_m[2];
        end
    end

    assign cs_rise   = (cs_m[1] == cs_m[2]) && cs_m[2] && !cs_st;
    assign cs_fall   = (cs_m[1] == cs_m[2]) && !cs_m[2] && cs_st;
    assign exec      = clk_en && cs_rise && frame_ok;
    assign bits_ok   = (lk_cnt_lo == 3'h0);
    assign pin_lock  = lock && !pr_st;
    assign wr_addr_w = {lk_b1, lk_b2};
    assign top2      = wr_addr_w[ADDR_W-1 -: 2];
    assign prog_done = (prog_cnt == 32'(PROG_CYC - 1));

    // guarded region per area guard setting
    always_comb
    begin
        case (guard)
            GUARD_NONE:    guarded = 1'b0;
            GUARD_QUARTER: guarded = (top2 == 2'h3);
            GUARD_HALF:    guarded = top2[1];
            GUARD_ALL:     guarded = 1'b1;
            default:       guarded = 1'b1;
        endcase
    end

    // power-up select gating: a frame counts only after a high was seen
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            armed    <= 1'b0;
            frame_ok <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cs_st)
                armed <= 1'b1;
            if (cs_fall)
                frame_ok <= armed;
            else if (cs_rise)
                frame_ok <= 1'b0;
        end
    end

    // permit latch; cycle end clears it after the cycle really ran
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            permit <= PERMIT_RST;
        else if (clk_en)
        begin
            if (state != ST_IDLE && prog_done)
                permit <= 1'b0;
            else if (exec && state == ST_IDLE && bits_ok &&
                     lk_byte_cnt == BYTES_SIMPLE)
            begin
                if (lk_opcode == OP_SET_PERMIT)
                    permit <= 1'b1;
                else if (lk_opcode == OP_CLEAR_PERMIT)
                    permit <= 1'b0;
            end
        end
    end

    // busy sequencer; other opcodes including unknown ones do nothing
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state     <= ST_IDLE;
            busy_flag <= 1'b0;
            prog_cnt  <= 32'h0;
            pend      <= 8'h00;
        end
        else if (clk_en)
        begin
            case (state)
                ST_IDLE:
                begin
                    prog_cnt <= 32'h0;
                    if (exec && bits_ok && permit)
                    begin
                        if (lk_opcode == OP_STATUS_STORE &&
                            lk_byte_cnt == BYTES_STORE && !pin_lock)
                        begin
                            pend      <= lk_b1;
                            state     <= ST_STATUS;
                            busy_flag <= 1'b1;
                        end
                        else if (lk_opcode == OP_ARRAY_WRITE &&
                                 lk_byte_cnt >= BYTES_WR_MIN && !guarded)
                        begin
                            state     <= ST_ARRAY;
                            busy_flag <= 1'b1;
                        end
                    end
                end
                ST_ARRAY, ST_STATUS:
                begin
                    prog_cnt <= prog_cnt + 32'h1;
                    if (prog_done)
                    begin
                        state     <= ST_IDLE;
                        busy_flag <= 1'b0;
                    end
                end
                default:
                begin
                    state     <= ST_IDLE;
                    busy_flag <= 1'b0;
                end
            endcase
        end
    end

    // non-volatile bits take their new value only when the cycle ends
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            guard <= GUARD_RST;
            lock  <= LOCK_RST;
        end
        else if (clk_en && state == ST_STATUS && prog_done)
        begin
            guard <= {pend[ST_GUARD_HI], pend[ST_GUARD_LO]};
            lock  <= pend[ST_LOCK_BIT];
        end
    end

    // status image and output enable
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            stat_q        <= 8'h00;
            serial_out_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            stat_q <= {lock, 3'h0, guard, permit, busy_flag};
            serial_out_oe <= frame_ok && !cs_st && ps_st
                             && act_m[2] && act_m[1];
        end
    end

    // ---------------- checks ----------------
    sequence prog_end_s;
        state != ST_IDLE ##1 state == ST_IDLE;
    endsequence

    sequence set_cmd_s;
        exec && state == ST_IDLE && bits_ok && !prog_done &&
        lk_byte_cnt == BYTES_SIMPLE && lk_opcode == OP_SET_PERMIT;
    endsequence

    permit_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        set_cmd_s |=> permit)
        else $error("permit latch not set by set command");

    cycle_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        prog_end_s |-> !permit)
        else $error("permit latch survived a write cycle");

    busy_match_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        busy_flag == (state != ST_IDLE))
        else $error("busy flag differs from cycle state");

    busy_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && $rose(busy_flag) |-> busy_flag [*2])
        else $error("self-timed cycle too short");

    odd_bits_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec && !bits_ok && state == ST_IDLE |=> state == ST_IDLE)
        else $error("instruction ran with partial byte");

    pin_lock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec && pin_lock && lk_opcode == OP_STATUS_STORE
        && state == ST_IDLE |=> state != ST_STATUS)
        else $error("status store ran under pin lock");

    guard_blk_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec && guarded && lk_opcode == OP_ARRAY_WRITE
        && state == ST_IDLE |=> state != ST_ARRAY)
        else $error("write started inside guarded area");

    desel_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && cs_st |=> !serial_out_oe)
        else $error("output driven while deselected");

    unarmed_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !armed |-> !frame_ok ##1 !serial_out_oe)
        else $error("frame honoured before first high select");

    status_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        stat_q[6:4] == 3'h0)
        else $error("reserved status bits not zero");

endmodule // spief_front_end

`default_nettype wire

// ---- spief_master.sv ----
// bus master model standing at the far side of the serial link
`timescale 1ns/10ps
`default_nettype none

module spief_master (
    output logic      sclk,   // serial clock, 48 ns period
    output logic      cs_n,   // select, active low
    output logic      mosi,   // data to device
    output logic      hold_n, // pause, active low
    input  wire logic so,     // device data
    input  wire logic oe      // device drive enable
);
    logic cpol = 1'b0;           // idle level of the clock
    wire  miso = oe ? so : ~so;  // released line never shows a stale bit

    // idle bus, deselected and not paused
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        hold_n = 1'b1;
    end

    // high time before select arms the frame edge
    task automatic start(input logic pol);
        cpol = pol;
        sclk = pol;
        #64 cs_n = 1'b0;
    endtask

    // drive before rising, read after falling, msb first
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            #24 sclk = 1'b0;
            mosi = tx[i];
            if (i == 7)
                #48;                 // lets the drive enable settle
            #24 rx[i] = miso;
            sclk = 1'b1;
        end
    endtask

    // deselect before the next rising edge could come
    task automatic stop();
        #12 cs_n = 1'b1;
        #12 sclk = cpol;
        mosi = ~mosi;
    endtask

    // pause with clock low, junk toggles meanwhile
    task automatic pause(input logic drop);
        #24 sclk = 1'b0;
        #8 hold_n = 1'b0;
        repeat (4)
            #24 {sclk, mosi} = {~sclk, ~mosi};
        #24 cs_n = drop;
        #24 hold_n = 1'b1;
        #24;
    endtask
endmodule // spief_master

`default_nettype wire

// ---- spief_front_end_tb.sv ----
// self-checking bench for the serial eeprom front end
`timescale 1ns/10ps
`default_nettype none

module spief_front_end_tb;
    import spief_pkg::*;
    logic        clk_sys;      // system clock
    logic        sys_rst;      // supply reset
    logic        prot_n;       // protect pin
    logic        so;           // device data
    logic        oe;           // device drive enable
    logic        busy;         // self-timed cycle
    logic [14:0] addr;         // array address
    logic [7:0]  rx;           // last byte read
    logic [14:0] a;            // write or read address
    logic        seen_oe;      // enable at frame end
    logic        clk_en;       // system clock enable
    int          stall;        // frozen cycles in next busy count
    wire  [7:0]  mem_q = addr[7:0] ^ 8'hA5; // array model byte
    wire         sclk;         // serial clock
    wire         cs_n;         // select
    wire         mosi;         // data to device
    wire         hold_n;       // pause
    int          errors;       // mismatches
    int          total_checks; // comparisons

    spief_master u_spief_master (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .hold_n(hold_n), .so(so), .oe(oe));

    spief_front_end #(.ADDR_W(15), .PROG_CYC(8)) u_spief_front_end (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .shift_timing_input(sclk), .chip_enable_n(cs_n),
        .serial_in(mosi), .pause_pin_n(hold_n), .protect_pin_n(prot_n),
        .array_data(mem_q), .serial_out(so),
        .serial_out_oe(oe), .array_addr(addr), .busy_flag(busy));

    // 100 mhz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever
            #5 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] st(input logic l, input logic [1:0] g,
                                      input logic p);
        return {l, 3'h0, g, p, 1'b0};
    endfunction

    // lowest guarded address, 8000h meaning none
    function automatic logic [15:0] lim(input logic [1:0] g);
        return g == GUARD_NONE ? 16'h8000 : g == GUARD_QUARTER ? 16'h6000
             : g == GUARD_HALF ? 16'h4000 : 16'h0000;
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one select frame of nb bytes, the last one lb bits long
    task automatic frame(input logic [31:0] w, input int nb, input int lb,
                         input logic pol);
        u_spief_master.start(pol);
        for (int k = 0; k < nb; k++)
            u_spief_master.xfer(w[31-8*k -: 8], k == nb - 1 ? lb : 8, rx);
        seen_oe = oe;
        u_spief_master.stop();
    endtask

    task automatic fetch(input logic pol, input logic [7:0] exp);
        frame({OP_STATUS_FETCH, 24'h0}, 2, 8, pol);
        check(rx, exp);
        check({7'h0, seen_oe}, 8'h01);
        repeat (8) @(negedge clk_sys);
        check({7'h0, oe}, 8'h00);
    endtask

    // bounded wait for busy, then its length in cycles
    task automatic prog(input logic exp);
        int n;
        n = 0;
        for (int i = 0; i < 100 && busy !== 1'b1; i++)
            @(negedge clk_sys);
        while (busy === 1'b1 && n < 50)
        begin
            n++;
            clk_en = !(n > 2 && n <= 2 + stall);   // freeze mid-cycle
            @(negedge clk_sys);
        end
        clk_en = 1'b1;
        check(8'(n), exp ? 8'(8 + stall) : 8'h00);
    endtask

    task automatic permit();
        frame({OP_SET_PERMIT, 24'h0}, 1, 8, 1'b0);
    endtask

    // select already low at reset release must not arm a frame
    initial
    begin
        sys_rst = 1'b1;
        prot_n = 1'b1;
        errors = 0;
        total_checks = 0;
        clk_en = 1'b1;
        stall = 0;
        void'($urandom(32'hFF7998DB));
        #1 u_spief_master.cs_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk_sys);
        u_spief_master.xfer(OP_SET_PERMIT, 8, rx);
        u_spief_master.stop();
        fetch(1'b0, st(1'b0, GUARD_RST, PERMIT_RST));
        frame({OP_STATUS_STORE, 8'h0C, 16'h0}, 2, 8, 1'b0);
        prog(1'b0);
        permit();
        fetch(1'b1, st(1'b0, 2'h0, 1'b1));
        frame({OP_CLEAR_PERMIT, 24'h0}, 1, 8, 1'b1);
        fetch(1'b0, st(1'b0, 2'h0, 1'b0));
        permit();
        frame({OP_STATUS_STORE, 8'h0C, 16'h0}, 2, 7, 1'b0);
        prog(1'b0);
        // store split by a pause, junk bits in ignored positions
        u_spief_master.start(1'b0);
        u_spief_master.xfer(OP_STATUS_STORE, 8, rx);
        u_spief_master.pause(1'b0);
        u_spief_master.xfer(8'h8C | (8'($urandom) & 8'h73), 8, rx);
        u_spief_master.stop();
        prog(1'b1);
        fetch(1'b0, st(1'b1, GUARD_ALL, 1'b0));
        @(negedge clk_sys) prot_n = 1'b0;
        permit();
        frame({OP_STATUS_STORE, 8'h00, 16'h0}, 2, 8, 1'b0);
        prog(1'b0);
        @(negedge clk_sys) prot_n = 1'b1;
        frame({OP_STATUS_STORE, 8'h00, 16'h0}, 2, 8, 1'b0);
        stall = 1 + int'($urandom % 5);
        prog(1'b1);
        stall = 0;
        permit();
        u_spief_master.start(1'b0);
        u_spief_master.xfer(OP_STATUS_STORE, 8, rx);
        u_spief_master.pause(1'b1);
        prog(1'b0);
        fetch(1'b0, st(1'b0, 2'h0, 1'b1));
        // each guard setting against its boundary and a random address
        for (int g = 0; g < 4; g++)
        begin
            permit();
            frame({OP_STATUS_STORE, 4'h0, 2'(g), 2'h0, 16'h0}, 2, 8, 1'b0);
            prog(1'b1);
            for (int j = 0; j < 3; j++)
            begin
                a = j == 0 ? 15'(lim(2'(g)) - 16'h1)
                  : j == 1 ? 15'(lim(2'(g))) : 15'($urandom);
                permit();
                frame({OP_ARRAY_WRITE, 1'b0, a, 8'($urandom)}, 4, 8, 1'b0);
                prog({1'b0, a} < lim(2'(g)));
            end
        end
        frame({1'b1, 7'($urandom), 24'h0}, 2, 8, 1'b0);
        check({7'h0, seen_oe}, 8'h00);
        a = 15'($urandom);
        frame({OP_ARRAY_READ, 1'b0, a, 8'h00}, 4, 8, 1'b0);
        check(rx, a[7:0] ^ 8'hA5);
        a = a + 15'h1;
        check(addr[7:0], a[7:0]);
        check({1'b0, addr[14:8]}, {1'b0, a[14:8]});
        permit();
        @(negedge clk_sys) sys_rst = 1'b1;
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        fetch(1'b0, st(LOCK_RST, GUARD_RST, PERMIT_RST));
        tally_and_finish();
    end

    // cuts a hung run short
    initial
    begin
        #900000;
        errors++;
        tally_and_finish();
    end
endmodule // spief_front_end_tb

`default_nettype wire
